// file: design/coa_params.svh
// Purpose: constants of the operand-addressing core
// Assumes: included by the decode, alu and core design files of the core; the type package does not include it
// Notes: opcode values follow the instruction summary of the processor
`ifndef COA_PARAMS_SVH
`define COA_PARAMS_SVH

// reset values
`define COA_BYTE_RST 8'h00
`define COA_PC_RST 16'h0000

// software register indices
`define COA_REG_ACC 3'h0
`define COA_REG_IDX 3'h1
`define COA_REG_SP 3'h2
`define COA_REG_PCL 3'h3
`define COA_REG_PCH 3'h4
`define COA_REG_FLAGS 3'h5
`define COA_REG_CTRL 3'h6
`define COA_REG_STAT 3'h7

// bit positions
`define COA_FLAG_C 0
`define COA_FLAG_Z 1
`define COA_FLAG_XIO 4
`define COA_CTRL_RUN 0
`define COA_STAT_BUSY 0
`define COA_STAT_ILL 1

// opcodes
`define COA_OP_ADD_XA 8'h05
`define COA_OP_ADD_DI 8'h06
`define COA_OP_ADD_XI 8'h07
`define COA_OP_OR_XA 8'h2D
`define COA_OP_OR_DI 8'h2E
`define COA_OP_OR_XI 8'h2F
`define COA_OP_XOR_XA 8'h35
`define COA_OP_XOR_DI 8'h36
`define COA_OP_XOR_XI 8'h37
`define COA_OP_MVI_SRC 8'h3E
`define COA_OP_MVI_DST 8'h3F
`define COA_OP_MOV_DD 8'h5F
`define COA_OP_MOV_RXA 8'h61
`define COA_OP_MOV_RDI 8'h62
`define COA_OP_MOV_RXI 8'h63

// instruction lengths and steps
`define COA_LEN2 2'h2
`define COA_LEN3 2'h3
`define COA_PC_STEP 16'h0001
`define COA_PTR_STEP 8'h01
`endif

// file: design/coa_pkg.sv
// Purpose: types of the operand-addressing core
// Assumes: nothing
// Notes: state codes are one-hot
package coa_pkg;
  typedef enum logic [2:0] {MD_XA, MD_DI, MD_XI, MD_DD, MD_MVS, MD_MVD, MD_BAD} coa_mode_t;
  typedef enum logic [1:0] {ALU_MOV, ALU_ADD, ALU_OR, ALU_XOR} coa_alu_t;
  typedef enum logic [9:0] {
    S_IDLE = 10'h001,
    S_OPC = 10'h002,
    S_OP1 = 10'h004,
    S_OP2 = 10'h008,
    S_ADR = 10'h010,
    S_RD = 10'h020,
    S_CAP = 10'h040,
    S_RDI = 10'h080,
    S_LDA = 10'h100,
    S_WR = 10'h200
  } coa_state_t;
endpackage

// file: design/coa_decode.sv
// Purpose: opcode to addressing mode, operation, space and length
// Assumes: opcode held stable by the core
// Notes: unknown opcodes give MD_BAD
`timescale 1ns/10ps
`default_nettype none
`include "coa_params.svh"
module coa_decode
  import coa_pkg::*;
(
  // opcode
  input wire logic [7:0] opcode,
  // decoded
  output var coa_mode_t mode,
  output var coa_alu_t aluOp,
  output logic regSpace,
  output logic [1:0] len
);
  always_comb
  begin
    mode = MD_BAD;
    aluOp = ALU_MOV;
    regSpace = 1'b0;
    unique case (opcode)
      `COA_OP_ADD_XA: begin mode = MD_XA; aluOp = ALU_ADD; end
      `COA_OP_ADD_DI: begin mode = MD_DI; aluOp = ALU_ADD; end
      `COA_OP_ADD_XI: begin mode = MD_XI; aluOp = ALU_ADD; end
      `COA_OP_OR_XA: begin mode = MD_XA; aluOp = ALU_OR; end
      `COA_OP_OR_DI: begin mode = MD_DI; aluOp = ALU_OR; end
      `COA_OP_OR_XI: begin mode = MD_XI; aluOp = ALU_OR; end
      `COA_OP_XOR_XA: begin mode = MD_XA; aluOp = ALU_XOR; end
      `COA_OP_XOR_DI: begin mode = MD_DI; aluOp = ALU_XOR; end
      `COA_OP_XOR_XI: begin mode = MD_XI; aluOp = ALU_XOR; end
      `COA_OP_MOV_DD: mode = MD_DD;
      `COA_OP_MVI_SRC: mode = MD_MVS;
      `COA_OP_MVI_DST: mode = MD_MVD;
      `COA_OP_MOV_RXA: begin mode = MD_XA; regSpace = 1'b1; end
      `COA_OP_MOV_RDI: begin mode = MD_DI; regSpace = 1'b1; end
      `COA_OP_MOV_RXI: begin mode = MD_XI; regSpace = 1'b1; end
      default: mode = MD_BAD;
    endcase
  end
  assign len = (mode == MD_DI || mode == MD_XI || mode == MD_DD) ? `COA_LEN3 : `COA_LEN2;
endmodule
`default_nettype wire

// file: design/coa_alu.sv
// Purpose: result of move, add, or, xor with carry
// Assumes: purely combinational
// Notes: move passes the second source
`timescale 1ns/10ps
`default_nettype none
`include "coa_params.svh"
module coa_alu
  import coa_pkg::*;
(
  // sources
  input wire logic [7:0] srcA,
  input wire logic [7:0] srcB,
  input wire coa_alu_t op,
  // result
  output logic [7:0] res,
  output logic carry
);
  logic [8:0] sum;
  assign sum = {1'b0, srcA} + {1'b0, srcB};
  assign res = (op == ALU_ADD) ? sum[7:0] :
               (op == ALU_OR) ? (srcA | srcB) :
               (op == ALU_XOR) ? (srcA ^ srcB) : srcB;
  assign carry = (op == ALU_ADD) & sum[8];
endmodule
`default_nettype wire

// file: design/coa_core.sv
// Purpose: core registers and operand addressing of an 8-bit processor
// Assumes: code and data memories answer one cycle after their read strobe
// Notes: software reaches core registers over a plain strobe port
// Operation
// (RULE1) register-space access beyond page needs extended select
// (RULE2) 8-bit accumulator, cleared at reset
// (RULE3) 8-bit index register, cleared, feeds indexed modes
// (RULE4) 8-bit stack pointer, cleared at reset
// (RULE5) 16-bit program counter, two bytes, cleared
// (RULE6) result goes to RAM or register space
// (RULE7) dest indexed: op1 plus index, accumulator source
// (RULE8) arithmetic to memory keeps accumulator unchanged
// (RULE9) dest direct, immediate source, three bytes
// (RULE10) dest indexed, immediate source, three bytes
// (RULE11) direct to direct only for move
// (RULE12) indirect source loads pointed byte into accumulator
// (RULE13) indirect dest stores accumulator at pointer
// (RULE14) indirect pointer incremented and written back
// (RULE15) indirect modes decoded only for indirect move
// (RULE16) fetch opcode, operand 1, operand 2 in order
`timescale 1ns/10ps
`default_nettype none
`include "coa_params.svh"
module coa_core
  import coa_pkg::*;
#(
  parameter int ADDR_W = 8
)
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // software register port
  input wire logic [2:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  output logic [7:0] regRdData,
  // code memory
  output logic [15:0] codeAddr,
  output logic codeRd,
  input wire logic [7:0] codeData,
  // data memory and register space
  output logic [ADDR_W-1:0] memAddr,
  output logic memRd,
  output logic memWr,
  output logic [7:0] memWrData,
  output logic memRegSpace,
  output logic memExtSpace,
  input wire logic [7:0] memRdData
);
  // the datapath, pointers and page wrap are one byte wide
  if (ADDR_W != 8)
  begin
    $error("coa_core serves an 8-bit data address only");
  end

  coa_state_t stateQ, stateD;
  logic [7:0] accQ, idxQ, spQ, pchQ, pclQ, flagsQ, ctrlQ;
  logic [7:0] opcQ, op1Q, op2Q, ptrQ, addrQ, wdatQ;
  logic regSpQ, illQ, ptrWrQ;
  logic mvdAgain;
  coa_mode_t mode;
  coa_alu_t aluOp;
  logic decReg;
  logic [1:0] len;
  logic [7:0] aluB, aluRes, ea, ptrInc;
  logic aluC;
  logic [15:0] pcNow, pcNext;
  logic run, isArith, needRd, isMvi, swAcc, swIdx, swSp, swPcl, swPch, swFlg, swCtl;
  logic [7:0] rdSel;

  coa_decode uDec (
    .opcode(opcQ),
    .mode(mode),
    .aluOp(aluOp),
    .regSpace(decReg),
    .len(len)
  );

  coa_alu uAlu (
    .srcA(memRdData),
    .srcB(aluB),
    .op(aluOp),
    .res(aluRes),
    .carry(aluC)
  );

  // software strobes
  assign swAcc = regWr && regAddr == `COA_REG_ACC;
  assign swIdx = regWr && regAddr == `COA_REG_IDX;
  assign swSp = regWr && regAddr == `COA_REG_SP;
  assign swPcl = regWr && regAddr == `COA_REG_PCL;
  assign swPch = regWr && regAddr == `COA_REG_PCH;
  assign swFlg = regWr && regAddr == `COA_REG_FLAGS;
  assign swCtl = regWr && regAddr == `COA_REG_CTRL;
  assign run = ctrlQ[`COA_CTRL_RUN];

  // addressing
  assign pcNow = {pchQ, pclQ}; // RULE5
  assign pcNext = pcNow + `COA_PC_STEP;
  assign isMvi = mode == MD_MVS || mode == MD_MVD; // RULE15
  assign isArith = aluOp != ALU_MOV;
  assign needRd = isArith || mode == MD_DD || isMvi;
  // indexed modes wrap inside the 256-byte page
  assign ea = (mode == MD_XA || mode == MD_XI) ? op1Q + idxQ : op1Q; // RULE3 RULE7 RULE10
  assign aluB = (mode == MD_DD) ? memRdData : (mode == MD_XA) ? accQ : op2Q; // RULE9 RULE10
  assign ptrInc = ptrQ + `COA_PTR_STEP;
  // destination indirect writes twice; a phase bit picks the pointer write-back,
  // since the pointer may name its own holder and an address compare would miss it
  assign mvdAgain = mode == MD_MVD && ptrWrQ; // RULE13 RULE14

  // next state
  always_comb
  begin
    stateD = stateQ;
    unique case (stateQ)
      S_IDLE: if (run) stateD = S_OPC;
      S_OPC: stateD = S_OP1;
      S_OP1:
      begin
        if (mode == MD_BAD)
          stateD = S_IDLE;
        else if (len == `COA_LEN3)
          stateD = S_OP2;
        else
          stateD = S_ADR;
      end
      S_OP2: stateD = S_ADR;
      S_ADR: stateD = needRd ? S_RD : S_WR;
      S_RD: stateD = S_CAP;
      S_CAP: stateD = (mode == MD_MVS) ? S_RDI : S_WR;
      S_RDI: stateD = S_LDA;
      S_LDA: stateD = S_WR;
      S_WR: stateD = mvdAgain ? S_WR : S_IDLE; // RULE14
      default: stateD = S_IDLE;
    endcase
  end

  // code fetch strobes
  // fetch starts from idle so no cycle is lost between instructions
  assign codeRd = (stateQ == S_IDLE && run) || stateQ == S_OPC
                  || (stateQ == S_OP1 && mode != MD_BAD && len == `COA_LEN3); // RULE16
  assign codeAddr = pcNow;

  // data memory strobes
  assign memRd = stateQ == S_RD || stateQ == S_RDI;
  assign memWr = stateQ == S_WR;
  assign memAddr = addrQ;
  assign memWrData = wdatQ;
  assign memRegSpace = regSpQ && (memRd || memWr); // RULE6
  assign memExtSpace = memRegSpace && flagsQ[`COA_FLAG_XIO]; // RULE1

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      stateQ <= S_IDLE;
    else
      stateQ <= stateD;
  end

  // program counter: one step per fetched byte
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      pchQ <= `COA_BYTE_RST; // RULE5
      pclQ <= `COA_BYTE_RST; // RULE5
    end
    else if (swPch || swPcl)
    begin
      pchQ <= swPch ? regWrData : pchQ;
      pclQ <= swPcl ? regWrData : pclQ;
    end
    else if (codeRd)
    begin
      pchQ <= pcNext[15:8]; // RULE16
      pclQ <= pcNext[7:0]; // RULE16
    end
  end

  // instruction bytes
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      opcQ <= `COA_BYTE_RST;
      op1Q <= `COA_BYTE_RST;
      op2Q <= `COA_BYTE_RST;
    end
    else
    begin
      if (stateQ == S_OPC)
        opcQ <= codeData; // RULE16
      if (stateQ == S_OP1)
        op1Q <= codeData; // RULE16
      if (stateQ == S_OP2)
        op2Q <= codeData; // RULE16
    end
  end

  // core registers; a software write wins over the core's own update
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      accQ <= `COA_BYTE_RST; // RULE2
      idxQ <= `COA_BYTE_RST; // RULE3
      spQ <= `COA_BYTE_RST; // RULE4
    end
    else
    begin
      if (swAcc)
        accQ <= regWrData;
      else if (stateQ == S_LDA)
        accQ <= memRdData; // RULE2 RULE12
      if (swIdx)
        idxQ <= regWrData;
      if (swSp)
        spQ <= regWrData;
    end
  end

  // flags: carry and zero from arithmetic, zero also from the indirect load, extended select from software
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      flagsQ <= `COA_BYTE_RST;
    else if (swFlg)
      flagsQ <= regWrData;
    else if (stateQ == S_CAP && isArith)
    begin
      flagsQ[`COA_FLAG_C] <= aluC;
      flagsQ[`COA_FLAG_Z] <= aluRes == `COA_BYTE_RST;
    end
    else if (stateQ == S_LDA)
      flagsQ[`COA_FLAG_Z] <= memRdData == `COA_BYTE_RST;
  end

  // control and sticky bad-opcode status; a new bad opcode beats the clear
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      ctrlQ <= `COA_BYTE_RST;
      illQ <= 1'b0;
    end
    else
    begin
      if (stateQ == S_OP1 && mode == MD_BAD)
      begin
        ctrlQ[`COA_CTRL_RUN] <= 1'b0; // RULE15
        illQ <= 1'b1;
      end
      else
      begin
        if (swCtl)
          ctrlQ <= regWrData;
        if (swCtl && regWrData[`COA_CTRL_RUN])
          illQ <= 1'b0;
      end
    end
  end

  // operand addressing datapath
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      addrQ <= `COA_BYTE_RST;
      wdatQ <= `COA_BYTE_RST;
      ptrQ <= `COA_BYTE_RST;
      ptrWrQ <= 1'b0;
      regSpQ <= 1'b0;
    end
    else
    begin
      unique case (stateQ)
        S_ADR:
        begin
          regSpQ <= decReg && !isMvi; // RULE6 RULE11
          if (mode == MD_DD)
            addrQ <= op2Q; // RULE11
          else
            addrQ <= ea; // RULE7 RULE9 RULE10 RULE12 RULE13
          // moves without a read write the second source straight away
          wdatQ <= aluB; // RULE9 RULE10
        end
        S_CAP:
        begin
          ptrWrQ <= mode == MD_MVD; // RULE13
          if (isMvi)
          begin
            ptrQ <= memRdData; // RULE12 RULE13
            addrQ <= memRdData; // RULE12 RULE13
            wdatQ <= accQ; // RULE13
          end
          else
          begin
            addrQ <= ea; // RULE11
            wdatQ <= aluRes; // RULE7 RULE8
          end
        end
        S_LDA:
        begin
          addrQ <= op1Q; // RULE14
          wdatQ <= ptrInc; // RULE14
        end
        S_WR:
        begin
          if (mvdAgain)
          begin
            addrQ <= op1Q; // RULE14
            wdatQ <= ptrInc; // RULE14
          end
          ptrWrQ <= 1'b0;
        end
        default:
        begin
          addrQ <= addrQ;
        end
      endcase
    end
  end

  // software read mux, answered one cycle after the read strobe
  // zero between reads, so a stale answer is never taken for a fresh one
  assign rdSel = (regAddr == `COA_REG_ACC) ? accQ :
                 (regAddr == `COA_REG_IDX) ? idxQ :
                 (regAddr == `COA_REG_SP) ? spQ :
                 (regAddr == `COA_REG_PCL) ? pclQ :
                 (regAddr == `COA_REG_PCH) ? pchQ :
                 (regAddr == `COA_REG_FLAGS) ? flagsQ :
                 (regAddr == `COA_REG_CTRL) ? ctrlQ :
                 {6'h00, illQ, stateQ != S_IDLE};

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      regRdData <= `COA_BYTE_RST;
    else if (regRd)
      regRdData <= rdSel;
    else
      regRdData <= `COA_BYTE_RST;
  end
endmodule
`default_nettype wire

// file: bench/coa_checker.sv
// Purpose: port assertions for coa_core
// Assumes: one clock, rst asynchronous and active high
// Notes: extended select is mirrored from software writes to the flags register
`timescale 1ns/10ps
`default_nettype none
`include "coa_params.svh"
module coa_checker #(
  parameter int ADDR_W = 8
)
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // register port
  input wire logic [2:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  input wire logic [7:0] regRdData,
  // code memory
  input wire logic [15:0] codeAddr,
  input wire logic codeRd,
  input wire logic [7:0] codeData,
  // data memory
  input wire logic [ADDR_W-1:0] memAddr,
  input wire logic memRd,
  input wire logic memWr,
  input wire logic [7:0] memWrData,
  input wire logic memRegSpace,
  input wire logic memExtSpace,
  input wire logic [7:0] memRdData
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  logic xio_q;
  // only software touches the select bit, so port writes are enough to track it
  always_ff @(posedge clk or posedge rst)
    if (rst)
      xio_q <= 1'b0;
    else if (regWr && regAddr == `COA_REG_FLAGS)
      xio_q <= regWrData[`COA_FLAG_XIO];
  a_ext_select: assert property ((memRd || memWr) && memRegSpace |-> memExtSpace == xio_q)
    else $error("extended select does not follow flag");
  a_ext_ram: assert property (memExtSpace |-> memRegSpace)
    else $error("extended select outside register space");
  a_rd_idle: assert property (!$past(regRd) |-> regRdData == 8'h00)
    else $error("read data without read strobe");
  a_pc_advance: assert property (codeRd && !regWr |=> codeAddr == $past(codeAddr) + 16'h0001)
    else $error("pc did not advance on fetch");
  a_pc_hold: assert property (!codeRd && !regWr |=> $stable(codeAddr))
    else $error("pc moved without fetch");
  a_fetch_min: assert property ($rose(codeRd) |-> codeRd [*2])
    else $error("opcode and operand not fetched together");
  a_fetch_max: assert property ($rose(codeRd) |-> ##3 !codeRd)
    else $error("more than three code bytes fetched");
  a_fetch_excl: assert property (codeRd |-> !memRd && !memWr)
    else $error("data access during fetch");
  a_read_gap: assert property (memRd |=> !memRd)
    else $error("read data not captured before next read");
endmodule
bind coa_core coa_checker #(.ADDR_W(ADDR_W)) u_coa_checker (.clk(clk), .rst(rst),
  .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
  .regRdData(regRdData), .codeAddr(codeAddr), .codeRd(codeRd), .codeData(codeData),
  .memAddr(memAddr), .memRd(memRd), .memWr(memWr), .memWrData(memWrData),
  .memRegSpace(memRegSpace), .memExtSpace(memExtSpace), .memRdData(memRdData));
`default_nettype wire

// file: bench/coa_mem_model.sv
// Purpose: code memory, ram and register space beside the core
// Assumes: answers one cycle after each read strobe
// Notes: an idle bus shows the inverse of its last value, so stale data never matches
`timescale 1ns/10ps
`default_nettype none
module coa_mem_model
(
  // clock
  input wire logic clk,
  // code side
  input wire logic [15:0] codeAddr,
  input wire logic codeRd,
  output logic [7:0] codeData,
  // data side
  input wire logic [7:0] memAddr,
  input wire logic memRd,
  input wire logic memWr,
  input wire logic [7:0] memWrData,
  input wire logic memRegSpace,
  output logic [7:0] memRdData
);
  logic [7:0] code [256];
  logic [7:0] ram [256];
  logic [7:0] regs [256];
  always @(posedge clk)
  begin
    codeData <= codeRd ? code[codeAddr[7:0]] : ~codeData;
    memRdData <= !memRd ? ~memRdData : (memRegSpace ? regs[memAddr] : ram[memAddr]);
    if (memWr && memRegSpace)
      regs[memAddr] <= memWrData;
    if (memWr && !memRegSpace)
      ram[memAddr] <= memWrData;
  end
endmodule
`default_nettype wire

// file: bench/test_cpu_operand_addressing.sv
// Purpose: self-checking bench of coa_core
// Assumes: one clock, software port drives everything
// Notes: a bench mirror of ram predicts every data write
`timescale 1ns/10ps
`default_nettype none
`include "coa_params.svh"
module test_cpu_operand_addressing;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [2:0] regAddr = 3'h0;
  logic [7:0] regWrData = 8'h00;
  logic regWr = 1'b0;
  logic regRd = 1'b0;
  logic [7:0] regRdData, codeData, memWrData, memRdData, memAddr, seenRd;
  logic [15:0] codeAddr;
  logic codeRd, memRd, memWr, memRegSpace, memExtSpace;
  logic rdPend = 1'b0;
  logic [17:0] wrQ[$];
  logic [7:0] rdQ[$];
  logic [31:0] seed = 32'h0001_6C7C;
  int mismatches = 0;
  int total_checks = 0;
  coa_core #(.ADDR_W(8)) u_coa_core (.clk(clk), .rst(rst), .regAddr(regAddr),
    .regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData),
    .codeAddr(codeAddr), .codeRd(codeRd), .codeData(codeData), .memAddr(memAddr),
    .memRd(memRd), .memWr(memWr), .memWrData(memWrData), .memRegSpace(memRegSpace),
    .memExtSpace(memExtSpace), .memRdData(memRdData));
  coa_mem_model u_coa_mem_model (.clk(clk), .codeAddr(codeAddr), .codeRd(codeRd),
    .codeData(codeData), .memAddr(memAddr), .memRd(memRd), .memWr(memWr),
    .memWrData(memWrData), .memRegSpace(memRegSpace), .memRdData(memRdData));
  initial forever #4 clk = ~clk;
  function automatic logic [7:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[7:0];
  endfunction
  task automatic check(input string name, input logic [17:0] seen, input logic [17:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic report_and_stop();
    if (mismatches == 0 && total_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // one access takes two cycles so a strobe never rises in the edge that drops it
  task automatic regAcc(input logic wr, input logic [2:0] a, input logic [7:0] d);
    regWr <= wr;
    regRd <= !wr;
    regAddr <= a;
    regWrData <= d;
    @(posedge clk);
    regWr <= 1'b0;
    regRd <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [2:0] a, input logic [7:0] e);
    rdQ.push_back(e);
    regAcc(1'b0, a, 8'h00);
  endtask
  always @(posedge clk)
  begin
    if (rdPend && rdQ.size() > 0)
      check("regRdData", {10'h000, regRdData}, {10'h000, rdQ.pop_front()});
    // a software write starts a fresh poll, so an old status never ends it
    if (rdPend)
      seenRd <= regRdData;
    else if (regWr)
      seenRd <= 8'h00;
    if (memWr)
      check("memWr", {memExtSpace, memRegSpace, memAddr, memWrData},
        wrQ.size() ? wrQ.pop_front() : 18'h3_FFFF);
    rdPend <= regRd;
  end
  task automatic runProg(input logic [7:0] flg);
    logic [7:0] ops [15] = '{8'h05, 8'h06, 8'h07, 8'h2D, 8'h2E, 8'h2F, 8'h35, 8'h36,
      8'h37, 8'h5F, 8'h61, 8'h62, 8'h63, 8'h3F, 8'h3E};
    logic [7:0] ram [256];
    logic [7:0] acc, x, o1, o2, ad, v, p, src;
    logic rs, len3;
    int pc, n;
    acc = rnd();
    x = rnd();
    pc = 0;
    regAcc(1'b1, `COA_REG_ACC, acc);
    regAcc(1'b1, `COA_REG_IDX, x);
    for (int i = 0; i < 256; i++)
    begin
      ram[i] = rnd();
      u_coa_mem_model.ram[i] = ram[i];
    end
    foreach (ops[i])
    begin
      o1 = rnd();
      o2 = rnd();
      u_coa_mem_model.code[pc] = ops[i];
      u_coa_mem_model.code[pc + 1] = o1;
      u_coa_mem_model.code[pc + 2] = o2;
      rs = ops[i][7:4] == 4'h6;
      len3 = ops[i][1] && ops[i][7:1] != 7'h1F;
      src = len3 ? o2 : acc;
      ad = o1 + ((ops[i][0] && ops[i] != 8'h5F && ops[i] != 8'h3F) ? x : 8'h00);
      p = ram[o1];
      if (ops[i] == 8'h5F)
        v = ram[o2];
      else if (rs)
        v = src;
      else if (ops[i] == 8'h3F)
      begin
        wrQ.push_back({2'b00, p, acc});
        ram[p] = acc;
        v = p + 8'h01;
      end
      else if (ops[i] == 8'h3E)
      begin
        acc = ram[p];
        v = p + 8'h01;
      end
      else
        v = ops[i][7:4] == 4'h0 ? ram[ad] + src : ops[i][4] ? ram[ad] ^ src : ram[ad] | src;
      wrQ.push_back({flg[4] & rs, rs, ad, v});
      if (!rs)
        ram[ad] = v;
      pc = pc + (len3 ? 3 : 2);
    end
    u_coa_mem_model.code[pc] = 8'hFF;
    regAcc(1'b1, `COA_REG_PCL, 8'h00);
    regAcc(1'b1, `COA_REG_PCH, 8'h00);
    regAcc(1'b1, `COA_REG_FLAGS, flg);
    regAcc(1'b1, `COA_REG_CTRL, 8'h01);
    n = 0;
    // the bad opcode at the end stops the core, polled over the register port
    while (seenRd[`COA_STAT_ILL] !== 1'b1 && n < 200)
    begin
      regAcc(1'b0, `COA_REG_STAT, 8'h00);
      n++;
    end
    // let the last status answer drain before the next expectation is queued
    @(posedge clk);
    if (n >= 200)
    begin
      mismatches++;
      report_and_stop();
    end
    check("pending", 18'(wrQ.size()), 18'h0_0000);
    rd(`COA_REG_ACC, acc);
    rd(`COA_REG_IDX, x);
    rd(`COA_REG_PCL, 8'(pc + 2));
    rd(`COA_REG_PCH, 8'h00);
  endtask
  initial
  begin
    logic [7:0] v;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 5; i++)
      rd(i[2:0], 8'h00);
    for (int i = 0; i < 5; i++)
    begin
      v = rnd();
      regAcc(1'b1, i[2:0], v);
      rd(i[2:0], v);
    end
    runProg(8'h00);
    runProg(8'h10);
    @(posedge clk);
    check("pendingRd", 18'(rdQ.size()), 18'h0_0000);
    report_and_stop();
  end
endmodule
`default_nettype wire
